// *** rtl/gpc_pin_config.sv ***
// gpio pin configuration registers, pin drive and pin interrupts
//
// How it works
// - interrupt-allow bit gates pin interrupts, any direction
// - edge triggered; shared line waits all inactive
// - driven output level can raise its interrupt
// - polarity bit set means falling edge
// - threshold bit selects ttl, else cmos
// - strong-sink bit selects higher sink current
// - open drain: one floats, zero pulls low
// - push-pull drives both levels from data
// - pull-up bit connects pull-up resistor
// - output-enable bit switches driver, unless overridden
// - crystal on: oscillator pins ignore config, undriven
// - regulator/serial pins: gpio enable needs select clear
// - serial block owns enable of its pins
// - low-volt bit sources high from regulator
// - clock-out bit drives selected clock onto pin
// - three dedicated pins give separate edge interrupts
// - dedicated pin as output self-triggers via data
// - data write sets drive, read returns pins
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
module gpc_pin_config
  import gpc_pkg::*;
#(
  parameter int NPINS = gpc_pkg::NUM_PINS
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [gpc_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [gpc_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_write,
  input  wire logic                          reg_read,
  output logic      [gpc_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic [gpc_pkg::NUM_PINS-1:0]  pin_in,
  output logic      [gpc_pkg::NUM_PINS-1:0]  pin_out,
  output logic      [gpc_pkg::NUM_PINS-1:0]  pin_oe,
  output logic      [gpc_pkg::NUM_PINS-1:0]  pin_pullup,
  output logic      [gpc_pkg::NUM_PINS-1:0]  pin_ttl,
  output logic      [gpc_pkg::NUM_PINS-1:0]  pin_high_sink,
  output logic      [gpc_pkg::NUM_SPI-1:0]   spi_low_volt,
  input  wire logic [gpc_pkg::NUM_SPI-1:0]   spi_out,
  input  wire logic [gpc_pkg::NUM_SPI-1:0]   spi_oe,
  input  wire logic [gpc_pkg::NUM_CLKS-1:0]  clk_src,
  output logic                               crystal_osc_on,
  output logic                               regulator_on,
  output logic                               regulator_pin_claim,
  output logic      [gpc_pkg::NUM_EXT-1:0]   ext_irq,
  output logic                               gpio_irq
);
  import gpc_pkg::*;

  // =======================================================
  // register state
  logic [7:0]       cfg_reg [NPINS];
  logic [NPINS-1:0] data_reg;
  logic [7:0]       clock_io_reg;
  logic [7:0]       regulator_reg;
  logic [7:0]       rdata_reg;
  logic [NPINS-1:0] out_reg;
  logic [NPINS-1:0] oe_reg;
  logic [NPINS-1:0] pullup_reg;
  logic [NPINS-1:0] ttl_reg;
  logic [NPINS-1:0] sink_reg;
  logic [NUM_SPI-1:0] low_volt_reg;
  logic [NUM_EXT-1:0] ext_irq_reg;
  logic             shared_d_reg;
  logic             shared_irq_reg;

  // =======================================================
  // address decode
  wire wr_data_lo = reg_write & (reg_addr == OFS_DATA_LO);
  wire wr_data_hi = reg_write & (reg_addr == OFS_DATA_HI);
  wire wr_clk_io  = reg_write & (reg_addr == OFS_CLOCK_IO_CTRL);
  wire wr_regctl  = reg_write & (reg_addr == OFS_REGULATOR_CTRL);

  wire in_low_cfg  = (reg_addr >= OFS_OSC_IN_PIN_CFG) && (reg_addr <= OFS_EXT_IRQ2_CFG);
  wire in_high_cfg = (reg_addr >= OFS_REG_PIN_CFG) && (reg_addr <= OFS_SPI_PIN3_CFG);
  wire cfg_hit     = in_low_cfg | in_high_cfg;
  wire [7:0] low_idx  = reg_addr - OFS_OSC_IN_PIN_CFG;
  wire [7:0] high_idx = (reg_addr - OFS_REG_PIN_CFG) + 8'(PIN_REG);
  wire [7:0] cfg_idx  = in_low_cfg ? low_idx : high_idx;

  // per-pin writable masks, reserved bits stay zero
  function automatic logic [7:0] cfg_mask(input int idx);
    if (idx == PIN_OSC_IN)       cfg_mask = MASK_OSC_IN_PIN_CFG;
    else if (idx == PIN_OSC_OUT) cfg_mask = MASK_OSC_OUT_PIN_CFG;
    else if (idx < PIN_REG)      cfg_mask = MASK_EXT_CFG;
    else if (idx == PIN_REG)     cfg_mask = MASK_REG_CFG;
    else                         cfg_mask = MASK_SPI_CFG;
  endfunction

  // =======================================================
  // pin sensing
  logic [NPINS-1:0] level;
  logic [NPINS-1:0] active;
  logic [NPINS-1:0] edge_pulse;
  logic [NPINS-1:0] sense_en;

  wire       crystal_on = clock_io_reg[B_CRYSTAL_ON];
  wire       reg_claim  = regulator_reg[B_REG_CLAIM];
  wire [1:0] clk_sel    = clock_io_reg[B_CLK_SEL_LO +: 2];

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      // oscillator pins lose gpio function while the crystal runs
      if (gi == PIN_OSC_IN || gi == PIN_OSC_OUT) begin : g_osc
        assign sense_en[gi] = cfg_reg[gi][B_IRQ_EN] & ~crystal_on;
      end else begin : g_norm
        assign sense_en[gi] = cfg_reg[gi][B_IRQ_EN];
      end
      gpc_pin_sense u_sense (
        .clk        (clk),
        .rst        (rst),
        .pin_raw    (pin_in[gi]),
        .act_low    (cfg_reg[gi][B_ACT_LOW]),
        .irq_en     (sense_en[gi]),
        .level      (level[gi]),
        .active     (active[gi]),
        .edge_pulse (edge_pulse[gi])
      );
    end
  endgenerate

  // shared line fires only when the first source goes active
  wire shared_active = |(active & SHARED_IRQ_PINS[NPINS-1:0]);

  // =======================================================
  // pin drive decision
  logic [NPINS-1:0] gpio_oe;
  logic [NPINS-1:0] next_out;
  logic [NPINS-1:0] next_oe;
  logic [NPINS-1:0] next_pull;
  logic [NPINS-1:0] next_ttl;
  logic [NPINS-1:0] next_sink;
  wire  clk_pick = clk_src[clk_sel];

  // override conditions, later ones win inside the drive loop
  logic [NPINS-1:0] spi_claim;
  logic [NPINS-1:0] reg_claimed;
  logic [NPINS-1:0] clk_drive;
  logic [NPINS-1:0] osc_owned;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_ovr
      if (gi >= PIN_SPI0) begin : g_spi
        assign spi_claim[gi] = cfg_reg[gi][B_SPI_USE];
      end else begin : g_gpio
        assign spi_claim[gi] = 1'b0;
      end
      assign reg_claimed[gi] = (gi == PIN_REG) && reg_claim;
      assign clk_drive[gi]   = (gi == PIN_OSC_OUT) && cfg_reg[gi][B_CLK_OUT];
      // crystal has the last word, it must never see a driver
      assign osc_owned[gi]   = (gi == PIN_OSC_IN || gi == PIN_OSC_OUT) && crystal_on;
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      gpio_oe[i]   = cfg_reg[i][B_OE];
      next_pull[i] = cfg_reg[i][B_PULLUP];
      next_sink[i] = cfg_reg[i][B_HIGH_SINK];
      next_ttl[i]  = cfg_reg[i][B_TTL];
      if (cfg_reg[i][B_OPEN_DRN]) begin
        next_out[i] = 1'b0;
        next_oe[i]  = gpio_oe[i] & ~data_reg[i];
      end else begin
        next_out[i] = data_reg[i];
        next_oe[i]  = gpio_oe[i];
      end
      if (i >= PIN_SPI0) begin
        // low-volt bit shares position with the threshold bit here
        next_ttl[i] = 1'b0;
        if (spi_claim[i]) begin
          next_out[i] = spi_out[i-PIN_SPI0];
          next_oe[i]  = spi_oe[i-PIN_SPI0];
        end
      end
      if (reg_claimed[i]) begin
        next_out[i] = 1'b0;
        next_oe[i]  = 1'b0;
      end
      if (clk_drive[i]) begin
        next_out[i] = clk_pick;
        next_oe[i]  = 1'b1;
      end
      if (osc_owned[i]) begin
        next_out[i]  = 1'b0;
        next_oe[i]   = 1'b0;
        next_pull[i] = 1'b0;
        next_ttl[i]  = 1'b0;
        next_sink[i] = 1'b0;
      end
    end
  end

  // =======================================================
  // read mux, pins read back as synchronised levels
  logic [15:0] level_wide;
  assign level_wide = 16'(level);
  // indices past the last pin read as zero, not as unknown
  wire       idx_ok  = cfg_idx < 8'(NPINS);
  wire [7:0] cfg_rd  = idx_ok ? cfg_reg[cfg_idx[3:0]] : 8'h00;
  wire       sel_lo  = reg_addr == OFS_DATA_LO;
  wire       sel_hi  = reg_addr == OFS_DATA_HI;
  wire       sel_cio = reg_addr == OFS_CLOCK_IO_CTRL;
  wire       sel_reg = reg_addr == OFS_REGULATOR_CTRL;
  wire       cfg_wr  = reg_write & cfg_hit;
  wire [7:0] rd_mux =
    sel_lo  ? level_wide[7:0] :
    sel_hi  ? level_wide[15:8] :
    sel_cio ? clock_io_reg :
    sel_reg ? regulator_reg :
    cfg_hit ? cfg_rd : 8'h00;

  logic [15:0] data_wide;
  assign data_wide = 16'(data_reg);
  wire [15:0] data_next = {wr_data_hi ? reg_wdata : data_wide[15:8],
                           wr_data_lo ? reg_wdata : data_wide[7:0]};

  // =======================================================
  // register writes
  // configuration bytes, reserved bits forced to zero on write
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NPINS; i++) begin
        cfg_reg[i] <= CFG_RESET;
      end
    end else begin
      for (int i = 0; i < NPINS; i++) begin
        if (cfg_wr && (int'(cfg_idx) == i)) begin
          cfg_reg[i] <= reg_wdata & cfg_mask(i);
        end
      end
    end
  end

  // port data, read back separately as pin levels
  always_ff @(posedge clk) begin
    if (rst) begin
      data_reg <= '0;
    end else begin
      data_reg <= data_next[NPINS-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clock_io_reg <= CFG_RESET;
    end else if (wr_clk_io) begin
      clock_io_reg <= reg_wdata & MASK_CLOCK_IO;
    end
  end

  // claim and enable are separate bits on purpose
  always_ff @(posedge clk) begin
    if (rst) begin
      regulator_reg <= CFG_RESET;
    end else if (wr_regctl) begin
      regulator_reg <= reg_wdata & MASK_REGULATOR;
    end
  end

  // read data stands one cycle only, zero otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_read ? rd_mux : 8'h00;
    end
  end

  // =======================================================
  // registered outputs
  // pin drive, one cycle behind the configuration
  always_ff @(posedge clk) begin
    if (rst) begin
      out_reg <= '0;
      oe_reg  <= '0;
    end else begin
      out_reg <= next_out;
      oe_reg  <= next_oe;
    end
  end

  // pad controls
  always_ff @(posedge clk) begin
    if (rst) begin
      pullup_reg <= '0;
      ttl_reg    <= '0;
      sink_reg   <= '0;
    end else begin
      pullup_reg <= next_pull;
      ttl_reg    <= next_ttl;
      sink_reg   <= next_sink;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      low_volt_reg <= '0;
    end else begin
      for (int s = 0; s < NUM_SPI; s++) begin
        low_volt_reg[s] <= cfg_reg[PIN_SPI0+s][B_LOW_VOLT];
      end
    end
  end

  // dedicated lines go straight to the interrupt controller
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_irq_reg <= '0;
    end else begin
      ext_irq_reg <= edge_pulse[PIN_EXT0 +: NUM_EXT];
    end
  end

  // shared line: an edge while another source is active is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      shared_d_reg   <= 1'b0;
      shared_irq_reg <= 1'b0;
    end else begin
      shared_d_reg   <= shared_active;
      shared_irq_reg <= shared_active & ~shared_d_reg;
    end
  end

  assign reg_rdata           = rdata_reg;
  assign pin_out             = out_reg;
  assign pin_oe              = oe_reg;
  assign pin_pullup          = pullup_reg;
  assign pin_ttl             = ttl_reg;
  assign pin_high_sink       = sink_reg;
  assign spi_low_volt        = low_volt_reg;
  assign crystal_osc_on      = clock_io_reg[B_CRYSTAL_ON];
  assign regulator_on        = regulator_reg[B_REGULATOR_ON];
  assign regulator_pin_claim = regulator_reg[B_REG_CLAIM];
  assign ext_irq             = ext_irq_reg;
  assign gpio_irq            = shared_irq_reg;
endmodule

// *** rtl/gpc_pin_sense.sv ***
// one pin: input synchroniser, active-level and edge detection
`timescale 1ns/100ps
module gpc_pin_sense (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin_raw,
  input  wire logic act_low,
  input  wire logic irq_en,
  output logic      level,
  output logic      active,
  output logic      edge_pulse
);
  logic sync1_reg;
  logic sync2_reg;
  logic active_d_reg;
  logic edge_reg;
  wire  active_now = irq_en & (sync2_reg ^ act_low);

  // =======================================================
  // synchroniser and edge detector
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg    <= 1'b0;
      sync2_reg    <= 1'b0;
      active_d_reg <= 1'b0;
      edge_reg     <= 1'b0;
    end else begin
      sync1_reg    <= pin_raw;
      sync2_reg    <= sync1_reg;
      active_d_reg <= active_now;
      edge_reg     <= active_now & ~active_d_reg;
    end
  end

  assign level      = sync2_reg;
  assign active     = active_now;
  assign edge_pulse = edge_reg;
endmodule

// *** rtl/gpc_pkg.sv ***
// shared constants for the gpio pin configuration block
package gpc_pkg;
  // =======================================================
  // sizes
  localparam int NUM_PINS  = 10;
  localparam int NUM_EXT   = 3;
  localparam int NUM_SPI   = 4;
  localparam int NUM_CLKS  = 4;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 8;

  // =======================================================
  // register offsets
  localparam logic [7:0] OFS_DATA_LO        = 8'h00;
  localparam logic [7:0] OFS_DATA_HI        = 8'h01;
  localparam logic [7:0] OFS_OSC_IN_PIN_CFG      = 8'h05;
  localparam logic [7:0] OFS_OSC_OUT_PIN_CFG     = 8'h06;
  localparam logic [7:0] OFS_EXT_IRQ0_CFG   = 8'h07;
  localparam logic [7:0] OFS_EXT_IRQ1_CFG   = 8'h08;
  localparam logic [7:0] OFS_EXT_IRQ2_CFG   = 8'h09;
  localparam logic [7:0] OFS_CLOCK_IO_CTRL  = 8'h20;
  localparam logic [7:0] OFS_REGULATOR_CTRL = 8'h21;
  localparam logic [7:0] OFS_REG_PIN_CFG    = 8'h22;
  localparam logic [7:0] OFS_SPI_PIN0_CFG   = 8'h23;
  localparam logic [7:0] OFS_SPI_PIN3_CFG   = 8'h26;

  // =======================================================
  // pin indices
  localparam int PIN_OSC_IN  = 0;
  localparam int PIN_OSC_OUT = 1;
  localparam int PIN_EXT0    = 2;
  localparam int PIN_REG     = 5;
  localparam int PIN_SPI0    = 6;

  // =======================================================
  // pin configuration fields
  localparam int B_OE        = 0;
  localparam int B_PULLUP    = 1;
  localparam int B_OPEN_DRN  = 2;
  localparam int B_HIGH_SINK = 3;
  localparam int B_TTL       = 4;
  localparam int B_LOW_VOLT  = 4;
  localparam int B_ACT_LOW   = 5;
  localparam int B_IRQ_EN    = 6;
  localparam int B_CLK_OUT   = 7;
  localparam int B_SPI_USE   = 7;

  // clock_io_control and regulator_control fields
  localparam int B_CLK_SEL_LO   = 0;
  localparam int B_CRYSTAL_ON   = 7;
  localparam int B_REGULATOR_ON = 0;
  localparam int B_REG_CLAIM    = 1;

  // =======================================================
  // reset values and writable masks
  localparam logic [7:0] CFG_RESET        = 8'h00;
  localparam logic [7:0] MASK_OSC_IN_PIN_CFG   = 8'h7f;
  localparam logic [7:0] MASK_OSC_OUT_PIN_CFG  = 8'hff;
  localparam logic [7:0] MASK_EXT_CFG     = 8'h77;
  localparam logic [7:0] MASK_REG_CFG     = 8'h77;
  localparam logic [7:0] MASK_SPI_CFG     = 8'hff;
  localparam logic [7:0] MASK_CLOCK_IO    = 8'h83;
  localparam logic [7:0] MASK_REGULATOR   = 8'h03;
  localparam logic [9:0] SHARED_IRQ_PINS  = 10'h3e3;
endpackage

// *** testbench/gpc_pin_config_sva.sv ***
// port assertions for the pin configuration block
`timescale 1ns/100ps
module gpc_pin_config_sva
  import gpc_pkg::*;
(
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic                         reg_read,
  input wire logic [gpc_pkg::DATA_W-1:0]   reg_rdata,
  input wire logic [gpc_pkg::NUM_PINS-1:0] pin_in,
  input wire logic [gpc_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [gpc_pkg::NUM_PINS-1:0] pin_oe,
  input wire logic                         crystal_osc_on,
  input wire logic                         regulator_pin_claim,
  input wire logic [gpc_pkg::NUM_EXT-1:0]  ext_irq,
  input wire logic                         gpio_irq
);
  // ==========
  // port checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst_quiet;
    disable iff (1'b0) rst |=> pin_oe == 10'h000 && ext_irq == 3'h0 && !gpio_irq;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("active after reset");
  property p_rd_stand;
    !$past(reg_read) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("stray read data");
  property p_ext_one;
    ext_irq != 3'h0 |=> (ext_irq & $past(ext_irq)) == 3'h0;
  endproperty
  a_ext_one: assert property (p_ext_one) else $error("long pin request");
  property p_gpio_one;
    gpio_irq |=> !gpio_irq;
  endproperty
  a_gpio_one: assert property (p_gpio_one) else $error("long shared request");
  // an edge must lie a few cycles back, sync lag included
  property p_ext_cause;
    ext_irq != 3'h0 |-> (ext_irq & ($past(pin_in[4:2], 2) ^ $past(pin_in[4:2], 8))) == ext_irq;
  endproperty
  a_ext_cause: assert property (p_ext_cause) else $error("pin request without edge");
  property p_gpio_cause;
    gpio_irq |-> (($past(pin_in, 2) ^ $past(pin_in, 8)) & SHARED_IRQ_PINS) != 10'h000;
  endproperty
  a_gpio_cause: assert property (p_gpio_cause) else $error("shared without edge");
  property p_xtal;
    crystal_osc_on ##1 crystal_osc_on |-> pin_oe[1:0] == 2'b00 && pin_out[1:0] == 2'b00;
  endproperty
  a_xtal: assert property (p_xtal) else $error("oscillator pin driven");
  property p_claim;
    regulator_pin_claim ##1 regulator_pin_claim |-> !pin_oe[PIN_REG];
  endproperty
  a_claim: assert property (p_claim) else $error("regulator pin driven");
  c_ext: cover property (ext_irq[0]);
  c_gpio: cover property (gpio_irq);
  c_xtal: cover property (crystal_osc_on ##1 crystal_osc_on);
endmodule

// *** testbench/gpc_pin_world.sv ***
// external circuitry on the port pins
`timescale 1ns/100ps
module gpc_pin_world (
  input  wire logic       clk,
  input  wire logic [9:0] pin_out,
  input  wire logic [9:0] pin_oe,
  input  wire logic [9:0] pin_pullup,
  input  wire logic [9:0] ext_en,
  input  wire logic [9:0] ext_val,
  output logic      [9:0] pin_in
);
  // ==========
  // wire resolution
  logic [9:0] wander = 10'h155;
  // a floating line must not settle to a lucky value
  always @(posedge clk) wander <= ~wander;
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else pin_in[i] = wander[i];
    end
  end
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the pin configuration block
`timescale 1ns/100ps
module tb;
  import gpc_pkg::*;
  // ==========
  // stimulus and model state
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [9:0] ext_en = 10'h3ff;
  logic [9:0] ext_val = 10'h000;
  logic [3:0] spi_out = 4'h0;
  logic [3:0] spi_oe = 4'h0;
  logic [3:0] clk_src = 4'h0;
  logic [7:0] reg_rdata, c, d;
  logic [9:0] pin_in, pin_out, pin_oe, pin_pullup, pin_ttl, pin_high_sink;
  logic [3:0] spi_low_volt;
  logic [2:0] ext_irq;
  logic       crystal_osc_on, regulator_on, regulator_pin_claim, gpio_irq;
  int         n_fail = 0;
  int         tests_run = 0;
  int         p;
  int         adr [13] = '{'h05, 'h06, 'h07, 'h08, 'h09, 'h20, 'h21, 'h22, 'h23, 'h24, 'h25,
                           'h26, 'h30};
  int         msk [13] = '{'h7f, 'hff, 'h77, 'h77, 'h77, 'h83, 'h03, 'h77, 'hff, 'hff, 'hff,
                           'hff, 'h00};
  // address, config, pin, then level, own drive, pulses expected
  logic [31:0] irqs [10] = '{32'h07400205, 32'h07600201, 32'h07600204, 32'h07000204,
                             32'h08410307, 32'h09400405, 32'h05400005, 32'h26400904,
                             32'h05400000, 32'h26400905};
  always #12.5 clk = ~clk;
  gpc_pin_config uut (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pin_in,
    .pin_out, .pin_oe, .pin_pullup, .pin_ttl, .pin_high_sink, .spi_low_volt, .spi_out,
    .spi_oe, .clk_src, .crystal_osc_on, .regulator_on, .regulator_pin_claim, .ext_irq,
    .gpio_irq
  );
  gpc_pin_world ext (.clk, .pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val, .pin_in);
  // ==========
  // tasks
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // a gap cycle after each strobe keeps one assignment per step
  task automatic wr(input int a, input logic [7:0] v);
    reg_addr <= 8'(a);
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input int a, input logic [7:0] e);
    reg_addr <= 8'(a);
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk({2'b00, reg_rdata}, {2'b00, e});
    @(posedge clk);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic drive(input logic v, input logic own);
    if (own) wr(OFS_DATA_LO, 8'(v) << p);
    else ext_val[p] <= v;
  endtask
  task automatic edge_run(input logic [31:0] w);
    int n;
    n = 0;
    p = int'(w[15:8]);
    drive(!w[2], w[1]);
    repeat (4) @(posedge clk);
    wr(int'(w[31:24]), w[23:16]);
    repeat (6) @(posedge clk);
    drive(w[2], w[1]);
    repeat (10) begin
      @(posedge clk);
      #1 n += (p inside {[2:4]}) ? int'(ext_irq[p-2] === 1'b1) : int'(gpio_irq === 1'b1);
    end
    chk(10'(n), {9'h000, w[0]});
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========
  // sequence
  initial begin
    #1ms;
    n_fail++;
    complete_run;
  end
  initial begin
    void'($urandom(41));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (adr[i]) begin
      rd(adr[i], 8'h00);
      d = 8'($urandom) & 8'hbf;
      wr(adr[i], d);
      rd(adr[i], d & 8'(msk[i]));
    end
    foreach (adr[i]) wr(adr[i], 8'h00);
    for (int k = 0; k < 8; k++) begin
      c = 8'($urandom) & 8'h1f;
      d = 8'($urandom);
      p = k[0] ? PIN_EXT0 : PIN_OSC_IN;
      wr(OFS_DATA_LO, d);
      wr(k[0] ? OFS_EXT_IRQ0_CFG : OFS_OSC_IN_PIN_CFG, c);
      settle;
      chk(pin_oe[p], c[0] & ~(c[2] & d[p]));
      chk(pin_out[p], d[p] & ~c[2]);
      chk({pin_pullup[p], pin_ttl[p], pin_high_sink[p]}, {c[1], c[4], c[3] & ~k[0]});
      settle;
      rd(OFS_DATA_LO, pin_in[7:0]);
    end
    rd(OFS_DATA_HI, {6'h00, pin_in[9:8]});
    clk_src <= 4'h6;
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CLOCK_IO_CTRL, 8'(s));
      wr(OFS_OSC_OUT_PIN_CFG, 8'h81);
      settle;
      chk({pin_oe[1], pin_out[1]}, {1'b1, clk_src[s]});
    end
    wr(OFS_CLOCK_IO_CTRL, 8'h80);
    settle;
    chk({crystal_osc_on, pin_oe[1:0], pin_out[1:0]}, 5'h10);
    wr(OFS_CLOCK_IO_CTRL, 8'h00);
    wr(OFS_REG_PIN_CFG, 8'h01);
    wr(OFS_REGULATOR_CTRL, 8'h02);
    wr(OFS_SPI_PIN0_CFG, 8'h91);
    spi_oe <= 4'($urandom);
    spi_out <= 4'($urandom);
    settle;
    chk({pin_oe[PIN_REG], regulator_on, spi_low_volt[0], regulator_pin_claim}, 4'h3);
    chk({pin_oe[PIN_SPI0], pin_out[PIN_SPI0]}, {spi_oe[0], spi_out[0]});
    wr(OFS_REGULATOR_CTRL, 8'h01);
    wr(OFS_SPI_PIN0_CFG, 8'h01);
    settle;
    chk({pin_oe[PIN_REG], regulator_on, pin_oe[PIN_SPI0], regulator_pin_claim}, 4'he);
    foreach (adr[i]) wr(adr[i], 8'h00);
    wr(OFS_DATA_LO, 8'h00);
    foreach (irqs[i]) edge_run(irqs[i]);
    complete_run;
  end
endmodule
bind gpc_pin_config gpc_pin_config_sva u_sva (
  .clk(clk), .rst(rst), .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .crystal_osc_on(crystal_osc_on),
  .regulator_pin_claim(regulator_pin_claim), .ext_irq(ext_irq), .gpio_irq(gpio_irq)
);
